// >>> design/mode_seq_pkg.sv
package mode_seq_pkg;

   // ****************************************
   // register map (byte addresses)
   // ****************************************
   localparam logic [7:0] CTRL_ADDR   = 8'h00;  // control: requests and options
   localparam logic [7:0] STATUS_ADDR = 8'h04;  // live mode and step state
   localparam logic [7:0] IRQ_ADDR    = 8'h08;  // sticky events, write one to clear
   localparam logic [7:0] MASK_ADDR   = 8'h0C;  // event mask
   localparam logic [7:0] SETUP_ADDR  = 8'h10;  // power-up restart type

   // ****************************************
   // control fields
   // ****************************************
   localparam int CTRL_RUN_REQ   = 0;  // pulse: stopped to execution
   localparam int CTRL_HALT_REQ  = 1;  // pulse: execution to stopped
   localparam int CTRL_ERR_CLR   = 2;  // option: clear latched errors
   localparam int CTRL_RST_LO    = 3;  // restart type, two bits
   localparam int CTRL_LOCK_OUT  = 5;  // option: keep outputs locked in run
   localparam int CTRL_OUT_RESET = 6;  // option: reset outputs on halt
   localparam int CTRL_LOAD      = 7;  // level: online program load

   // ****************************************
   // status fields
   // ****************************************
   localparam int ST_RUN     = 0;  // execution mode
   localparam int ST_LOCKED  = 1;  // outputs locked
   localparam int ST_ERR     = 2;  // critical error latched
   localparam int ST_LOADING = 3;  // program replacement in progress
   localparam int ST_RESTART = 4;  // first process is restart process

   // ****************************************
   // event bits
   // ****************************************
   localparam int EV_ENTER_RUN  = 0;
   localparam int EV_ENTER_HALT = 1;
   localparam int EV_CRIT       = 2;
   localparam int EV_RESTART    = 3;
   localparam int EV_W          = 4;

   // restart types
   localparam logic [1:0] RST_NONE = 2'h0;
   localparam logic [1:0] RST_WARM = 2'h1;
   localparam logic [1:0] RST_COLD = 2'h2;

   // reset values
   localparam logic [1:0] SETUP_RESET = 2'h1;  // warm restart after power-up

   typedef enum logic [1:0] {
      RST_KIND_NONE,
      RST_KIND_WARM,
      RST_KIND_COLD
   } restart_kind_type;

   typedef enum {
      S_POWERUP,
      S_HALT,
      S_CHK_PROG,
      S_CLR_PAD,
      S_REMANENT,
      S_SYS_INIT,
      S_CHK_PERIPH,
      S_IN_SCAN,
      S_EXEC,
      S_OUT_SCAN,
      S_LOADING
   } seq_state_type;

endpackage : mode_seq_pkg

// >>> design/mode_seq.sv
// Overview of operation
// - exactly one mode: execution or stopped
// - run cycle: inputs, program, outputs
// - stopped: no program, no peripheral transfer
// - critical error forces stopped mode
// - requests from host or service inputs
// - run entry: check program, peripherals, start
// - run entry options: clear, restart, lock
// - halt: stop, lock; optional clear, reset
// - error in transition: halt until cleared
// - restart after power-up and program replacement
// - warm keeps remanent, cold clears all
// - restart steps in fixed order
// - plain start: only checks, no initialisation
// - restart process first, else main process
// - online load suspends without locking outputs
// - power-up restart type stored separately
// - power-up restarts to run unless error
// - input scan and output scan copy zones
module mode_seq
   import mode_seq_pkg::*;
(
   input  wire logic        clk_i,             // system clock, 40 MHz
   input  wire logic        rst_i,             // synchronous reset, active high
   // wishbone slave
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [7:0]  adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic      [31:0] dat_o,
   output logic             ack_o,
   // service inputs, asynchronous pins
   input  wire logic        svc_run_i,         // request execution mode
   input  wire logic        svc_halt_i,        // request stopped mode
   // activation and error sources
   input  wire logic        activation_done_i, // power-on activation finished
   input  wire logic        crit_err_i,        // critical error, level
   input  wire logic        prog_ok_i,         // program integrity good
   input  wire logic        periph_ok_i,       // peripherals match program
   input  wire logic        prog_done_i,       // one pass of the program ended
   // scratchpad and output zone data
   input  wire logic [15:0] in_units_i,        // input unit values
   input  wire logic [15:0] out_zone_i,        // output zone from scratchpad
   output logic      [15:0] in_zone_o,         // input zone written to scratchpad
   output logic      [15:0] out_units_o,       // output unit values
   output logic             out_locked_o,      // outputs disconnected
   output logic             prog_run_o,        // user program may execute
   output logic             first_restart_o,   // first process is restart process
   output logic             clr_pad_o,         // pulse: clear scratchpad
   output logic             clr_rem_o,         // pulse: clear remanent zone
   output logic             restore_rem_o,     // pulse: restore backed-up registers
   output logic             sys_init_o,        // pulse: init system registers
   output logic             run_mode_o,        // execution mode
   output logic             irq_o              // level interrupt
);

   // ****************************************
   // registers and state
   // ****************************************
   seq_state_type    state_r;        // sequencer state
   logic [7:0]       ctrl_r;         // stored options
   logic [1:0]       setup_r;        // power-up restart type
   logic [1:0]       rst_kind_r;     // restart chosen for this entry
   logic             err_r;          // latched critical error
   logic             lock_opt_r;     // lock outputs during run
   logic [EV_W-1:0]  irq_stat_r;     // sticky events
   logic [EV_W-1:0]  irq_mask_r;     // event mask
   logic             svc_run_m_r;    // synchroniser stage 1
   logic             svc_run_s_r;    // synchroniser stage 2
   logic             svc_run_d_r;    // edge history
   logic             svc_halt_m_r;
   logic             svc_halt_s_r;
   logic             svc_halt_d_r;
   logic             act_seen_r;     // activation already handled
   logic [EV_W-1:0]  ev;             // this cycle's events
   logic             wr_hit;
   logic             run_req;
   logic             halt_req;
   logic             crit;

   assign wr_hit = cyc_i && stb_i && we_i && !ack_o && sel_i[0];

   // ****************************************
   // bus slave: one wait, ack then drop
   // ****************************************
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
      end else begin
         ack_o <= cyc_i && stb_i && !ack_o;
      end
   end

   // read mux, registered; unmapped reads as zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_o <= 32'h0000_0000;
      end else if (cyc_i && stb_i && !we_i && !ack_o) begin
         unique case (adr_i)
            CTRL_ADDR:   dat_o <= {24'h000000, ctrl_r};
            STATUS_ADDR: dat_o <= {27'h0000000, first_restart_o, state_r == S_LOADING,
                                   err_r, out_locked_o, run_mode_o};
            IRQ_ADDR:    dat_o <= {28'h0000000, irq_stat_r};
            MASK_ADDR:   dat_o <= {28'h0000000, irq_mask_r};
            SETUP_ADDR:  dat_o <= {30'h00000000, setup_r};
            default:     dat_o <= 32'h0000_0000;
         endcase
      end
   end

   // control options; request bits are not stored, they act as pulses
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_r <= 8'h00;
      end else if (wr_hit && adr_i == CTRL_ADDR) begin
         ctrl_r <= dat_i[7:0] & 8'hFC;
      end
   end

   // power-up restart type, kept apart from host start type
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         setup_r <= SETUP_RESET;
      end else if (wr_hit && adr_i == SETUP_ADDR) begin
         setup_r <= dat_i[1:0];
      end
   end

   // ****************************************
   // service input synchronisers
   // ****************************************
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         svc_run_m_r  <= 1'b0;
         svc_run_s_r  <= 1'b0;
         svc_run_d_r  <= 1'b0;
         svc_halt_m_r <= 1'b0;
         svc_halt_s_r <= 1'b0;
         svc_halt_d_r <= 1'b0;
      end else begin
         svc_run_m_r  <= svc_run_i;
         svc_run_s_r  <= svc_run_m_r;
         svc_run_d_r  <= svc_run_s_r;
         svc_halt_m_r <= svc_halt_i;
         svc_halt_s_r <= svc_halt_m_r;
         svc_halt_d_r <= svc_halt_s_r;
      end
   end

   // either source may ask; host write or service edge
   assign run_req  = (wr_hit && adr_i == CTRL_ADDR && dat_i[CTRL_RUN_REQ])
                   || (svc_run_s_r && !svc_run_d_r);
   assign halt_req = (wr_hit && adr_i == CTRL_ADDR && dat_i[CTRL_HALT_REQ])
                   || (svc_halt_s_r && !svc_halt_d_r);
   assign crit     = crit_err_i;

   // ****************************************
   // error latch
   // ****************************************
   // set wins over clear so a fresh error is never lost
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         err_r <= 1'b0;
      end else if (crit) begin
         err_r <= 1'b1;
      end else if (state_r == S_HALT && run_req && ctrl_r[CTRL_ERR_CLR]) begin
         err_r <= 1'b0;
      end else if (run_mode_o && halt_req && ctrl_r[CTRL_ERR_CLR]) begin
         err_r <= 1'b0;
      end
   end

   // ****************************************
   // mode sequencer
   // ****************************************
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_r    <= S_POWERUP;
         rst_kind_r <= RST_NONE;
         lock_opt_r <= 1'b0;
         act_seen_r <= 1'b0;
      end else if (crit && state_r != S_HALT) begin
         state_r <= S_HALT;
      end else begin
         unique case (state_r)
            S_POWERUP: begin
               if (activation_done_i && !act_seen_r) begin
                  act_seen_r <= 1'b1;
                  rst_kind_r <= (setup_r == RST_NONE) ? RST_WARM : setup_r;
                  lock_opt_r <= 1'b0;
                  state_r    <= err_r ? S_HALT : S_CHK_PROG;
               end
            end
            S_HALT: begin
               // a latched error blocks leaving stopped mode unless CTRL_ERR_CLR is set
               if (run_req && (!err_r || ctrl_r[CTRL_ERR_CLR])) begin
                  rst_kind_r <= ctrl_r[CTRL_RST_LO +: 2];
                  lock_opt_r <= ctrl_r[CTRL_LOCK_OUT];
                  state_r    <= S_CHK_PROG;
               end
            end
            S_CHK_PROG: begin
               // integrity first in every entry path
               if (!prog_ok_i) begin
                  state_r <= S_HALT;
               end else if (rst_kind_r == RST_NONE) begin
                  state_r <= S_CHK_PERIPH;
               end else begin
                  state_r <= S_CLR_PAD;
               end
            end
            S_CLR_PAD:  state_r <= S_REMANENT;
            S_REMANENT: state_r <= S_SYS_INIT;
            S_SYS_INIT: state_r <= S_CHK_PERIPH;
            S_CHK_PERIPH: begin
               state_r <= periph_ok_i ? S_IN_SCAN : S_HALT;
            end
            S_IN_SCAN: begin
               state_r <= halt_req ? S_HALT : S_EXEC;
            end
            S_EXEC: begin
               if (halt_req) begin
                  state_r <= S_HALT;
               end else if (ctrl_r[CTRL_LOAD]) begin
                  state_r <= S_LOADING;
               end else if (prog_done_i) begin
                  state_r <= S_OUT_SCAN;
               end
            end
            S_OUT_SCAN: begin
               state_r <= halt_req ? S_HALT : S_IN_SCAN;
            end
            S_LOADING: begin
               // new program in place: restart with host-chosen type, warm if none is chosen
               if (!ctrl_r[CTRL_LOAD]) begin
                  rst_kind_r <= (ctrl_r[CTRL_RST_LO +: 2] == RST_NONE) ? RST_WARM
                                : ctrl_r[CTRL_RST_LO +: 2];
                  state_r    <= S_CHK_PROG;
               end
            end
         endcase
      end
   end

   // ****************************************
   // decoded outputs
   // ****************************************
   // execution mode covers the whole cycle and a load pause
   assign run_mode_o = (state_r == S_IN_SCAN) || (state_r == S_EXEC)
                    || (state_r == S_OUT_SCAN) || (state_r == S_LOADING);
   assign prog_run_o = (state_r == S_EXEC);

   // loading pause leaves outputs connected; stopped locks them
   // a load pause never locks, even when the run was entered with the lock option
   assign out_locked_o = !run_mode_o || (lock_opt_r && state_r != S_LOADING);
   assign first_restart_o = (rst_kind_r != RST_NONE);

   // one-cycle step strobes
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         clr_pad_o     <= 1'b0;
         clr_rem_o     <= 1'b0;
         restore_rem_o <= 1'b0;
         sys_init_o    <= 1'b0;
      end else begin
         clr_pad_o     <= (state_r == S_CLR_PAD);
         clr_rem_o     <= (state_r == S_REMANENT) && (rst_kind_r == RST_COLD);
         restore_rem_o <= (state_r == S_REMANENT) && (rst_kind_r == RST_WARM);
         sys_init_o    <= (state_r == S_SYS_INIT);
      end
   end

   // ****************************************
   // input and output scans
   // ****************************************
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         in_zone_o <= 16'h0000;
      end else if (state_r == S_IN_SCAN) begin
         in_zone_o <= in_units_i;
      end
   end

   // locked outputs hold disconnected value; optional reset on halt
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         out_units_o <= 16'h0000;
      end else if (run_mode_o && halt_req && ctrl_r[CTRL_OUT_RESET]) begin
         out_units_o <= 16'h0000;
      end else if (state_r == S_OUT_SCAN && !out_locked_o) begin
         out_units_o <= out_zone_i;
      end
   end

   // ****************************************
   // interrupts
   // ****************************************
   assign ev[EV_ENTER_RUN]  = (state_r == S_CHK_PERIPH) && periph_ok_i && !crit;
   assign ev[EV_ENTER_HALT] = run_mode_o && (halt_req || crit);
   assign ev[EV_CRIT]       = crit && !err_r;
   assign ev[EV_RESTART]    = (state_r == S_SYS_INIT);

   // set wins over a write-one clear in the same cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_stat_r <= '0;
      end else if (wr_hit && adr_i == IRQ_ADDR) begin
         irq_stat_r <= (irq_stat_r & ~dat_i[EV_W-1:0]) | ev;
      end else begin
         irq_stat_r <= irq_stat_r | ev;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_mask_r <= '0;
      end else if (wr_hit && adr_i == MASK_ADDR) begin
         irq_mask_r <= dat_i[EV_W-1:0];
      end
   end

   assign irq_o = |(irq_stat_r & irq_mask_r);

endmodule : mode_seq

// >>> tb/mode_seq_props.sv
// ****************************************
// checker: mode sequencing at the ports
// ****************************************
module mode_seq_props (
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        cyc_i,
   input wire logic        stb_i,
   input wire logic        ack_o,
   input wire logic        crit_err_i,
   input wire logic        prog_done_i,
   input wire logic [15:0] in_units_i,
   input wire logic [15:0] out_zone_i,
   input wire logic [15:0] in_zone_o,
   input wire logic [15:0] out_units_o,
   input wire logic        out_locked_o,
   input wire logic        prog_run_o,
   input wire logic        run_mode_o,
   input wire logic        clr_pad_o,
   input wire logic        clr_rem_o,
   input wire logic        restore_rem_o,
   input wire logic        sys_init_o
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // remanent step then system init follow the scratchpad clear
   sequence s_init_steps;
      ##[1:2] (clr_rem_o || restore_rem_o) ##[1:2] sys_init_o;
   endsequence
   // output scan: still in run, program suspended
   sequence s_out_scan;
      run_mode_o && !prog_run_o;
   endsequence
   AST_ACK_PULSE: assert property (cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
      else $error("bus ack is not a single pulse");
   AST_RUN_ONLY: assert property (prog_run_o |-> run_mode_o)
      else $error("program runs outside execution mode");
   AST_CRIT_STOP: assert property (crit_err_i |=> !run_mode_o && !prog_run_o)
      else $error("critical error did not stop");
   AST_STOP_LOCK: assert property (!run_mode_o |-> out_locked_o)
      else $error("outputs connected while stopped");
   AST_STOP_NO_IO: assert property (!run_mode_o && $past(!run_mode_o) |-> $stable(in_zone_o))
      else $error("input scan while stopped");
   AST_LOCK_HOLD: assert property (out_locked_o && $past(out_locked_o) && run_mode_o |-> $stable(out_units_o))
      else $error("locked outputs changed");
   AST_SCAN_AFTER_PASS: assert property (prog_run_o && prog_done_i && !crit_err_i |=> s_out_scan)
      else $error("no output scan after program pass");
   AST_OUT_COPY: assert property (prog_run_o && prog_done_i && !crit_err_i && !out_locked_o ##1 !crit_err_i
      |=> out_units_o == $past(out_zone_i))
      else $error("output zone not copied");
   AST_IN_COPY: assert property ($rose(prog_run_o) |-> in_zone_o == $past(in_units_i))
      else $error("input units not copied before program");
   AST_INIT_ORDER: assert property (clr_pad_o |-> s_init_steps)
      else $error("restart steps out of order");
   AST_REM_EXCL: assert property (!(clr_rem_o && restore_rem_o))
      else $error("remanent cleared and restored together");
endmodule : mode_seq_props

bind mode_seq mode_seq_props u_props (.*);

// >>> tb/host_svc_model.sv
// ****************************************
// host model: drives the service pins
// ****************************************
module host_svc_model (
   input  wire logic clk_i,
   input  wire logic run_req_i,  // bench asks for a run command
   input  wire logic halt_req_i, // bench asks for a halt command
   input  wire logic slow_i,     // answer late instead of promptly
   output logic      svc_run_o,
   output logic      svc_halt_o
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [3:0] run_cnt_r  = 4'h0; // countdown, pin high in last four counts
   logic [3:0] halt_cnt_r = 4'h0;
   // pin held four cycles so the two-stage synchroniser cannot miss it
   always_ff @(posedge clk_i) begin
      if (run_req_i) run_cnt_r <= slow_i ? 4'hA : 4'h5;
      else if (run_cnt_r != 4'h0) run_cnt_r <= run_cnt_r - 4'h1;
   end
   always_ff @(posedge clk_i) begin
      if (halt_req_i) halt_cnt_r <= slow_i ? 4'hA : 4'h5;
      else if (halt_cnt_r != 4'h0) halt_cnt_r <= halt_cnt_r - 4'h1;
   end
   assign svc_run_o  = (run_cnt_r != 4'h0) && (run_cnt_r < 4'h5);
   assign svc_halt_o = (halt_cnt_r != 4'h0) && (halt_cnt_r < 4'h5);
endmodule : host_svc_model

// >>> tb/mode_seq_bench.sv
module mode_seq_bench;
   import mode_seq_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;
   logic        clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
   logic [7:0]  adr_i = 8'h00;
   logic [3:0]  sel_i = 4'h0;
   logic [31:0] dat_i = 32'h0, dat_o, rd;
   logic        ack_o, svc_run_i, svc_halt_i, out_locked_o, prog_run_o, first_restart_o;
   logic        clr_pad_o, clr_rem_o, restore_rem_o, sys_init_o, run_mode_o, irq_o;
   logic        activation_done_i = 1'b0, crit_err_i = 1'b0, prog_done_i = 1'b0;
   logic        prog_ok_i = 1'b1, periph_ok_i = 1'b1;  // check results from the far side
   logic [15:0] in_units_i = 16'h0, out_zone_i = 16'h0, in_zone_o, out_units_o;
   logic        run_req = 1'b0, halt_req = 1'b0, slow = 1'b0, done_en = 1'b0;
   logic [1:0]  pc [4];  // pulse counts: pad, rem clear, restore, init
   int          fail_count = 0, tests_run = 0, cycles = 0, seed = 87;
   always #12.5 clk_i = ~clk_i;
   mode_seq u_dut (.*);
   host_svc_model u_host (.clk_i(clk_i), .run_req_i(run_req), .halt_req_i(halt_req), .slow_i(slow),
      .svc_run_o(svc_run_i), .svc_halt_o(svc_halt_i));
   // ****************************************
   // random data, pass pulses, pulse counts, timeout
   // ****************************************
   always @(posedge clk_i) begin
      cycles++;
      in_units_i  <= 16'($random(seed));
      out_zone_i  <= 16'($random(seed));
      prog_done_i <= done_en && ($random(seed) % 4 == 0); // only while no mode change is pending
      if (clr_pad_o === 1'b1) pc[0] <= pc[0] + 2'h1;
      if (clr_rem_o === 1'b1) pc[1] <= pc[1] + 2'h1;
      if (restore_rem_o === 1'b1) pc[2] <= pc[2] + 2'h1;
      if (sys_init_o === 1'b1) pc[3] <= pc[3] + 2'h1;
      if (cycles == 5000) begin
         fail_count++;
         print_verdict();
      end
   end
   task chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      tests_run++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] %0t %s", $time, msg);
      end
   endtask : chk
   // one classic cycle; the wait is bounded so a dead slave cannot hang us
   task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= w; adr_i <= a; dat_i <= d; sel_i <= 4'hF;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && n < 20);
      rd = dat_o;
      cyc_i <= 1'b0; stb_i <= 1'b0;
      @(posedge clk_i);
      if (n >= 20) chk(32'h0, 32'h1, "no bus ack");
   endtask : wb
   task idle(input int k);
      repeat (k) @(posedge clk_i);
   endtask : idle
   task wait_run;
      int n;
      n = 0;
      while (prog_run_o !== 1'b1 && n < 80) begin
         @(posedge clk_i);
         n++;
      end
      chk(prog_run_o, 1'b1, "program not started");
   endtask : wait_run
   task run_passes(input int k);
      done_en <= 1'b1;
      idle(k);
      done_en <= 1'b0;
      idle(3);
   endtask : run_passes
   task clr_pc;
      for (int i = 0; i < 4; i++) pc[i] = 2'h0;
   endtask : clr_pc
   task pulse_host(input logic h, input logic s);
      slow <= s;
      if (h) halt_req <= 1'b1; else run_req <= 1'b1;
      @(posedge clk_i);
      halt_req <= 1'b0; run_req <= 1'b0;
   endtask : pulse_host
   // init pulses expected for a restart kind: pad, rem clear, restore, init
   function logic [7:0] exp_pulses(input logic [1:0] k);
      case (k)
         RST_WARM: return 8'h45;
         RST_COLD: return 8'h51;
         default:  return 8'h00;
      endcase
   endfunction : exp_pulses
   task print_verdict;
      $display("comparisons %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : print_verdict
   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      clr_pc();
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      chk(out_locked_o, 1'b1, "outputs connected after reset");
      wb(1'b0, SETUP_ADDR, 32'h0); chk(rd, {30'h0, SETUP_RESET}, "setup reset value");
      wb(1'b0, 8'h14, 32'h0); chk(rd, 32'h0, "unmapped read");
      wb(1'b1, SETUP_ADDR, {30'h0, RST_COLD});
      wb(1'b1, CTRL_ADDR, 32'h08);
      wb(1'b0, CTRL_ADDR, 32'h0); chk(rd, 32'h08, "control readback");
      activation_done_i <= 1'b1;
      wait_run();
      chk({pc[0], pc[1], pc[2], pc[3]}, exp_pulses(RST_COLD), "power-up restart kind");
      chk(first_restart_o, 1'b1, "restart process not first");
      wb(1'b1, MASK_ADDR, 32'h0F); chk(irq_o, 1'b1, "restart event not raised");
      wb(1'b1, IRQ_ADDR, 32'h0F); chk(irq_o, 1'b0, "event not cleared");
      wb(1'b1, MASK_ADDR, 32'h0);
      run_passes(60);
      crit_err_i <= 1'b1;
      @(posedge clk_i);
      crit_err_i <= 1'b0;
      idle(2);
      chk(run_mode_o, 1'b0, "critical error did not stop");
      chk(irq_o, 1'b0, "masked event raised irq");
      wb(1'b1, MASK_ADDR, 32'h1 << EV_CRIT); chk(irq_o, 1'b1, "critical event irq");
      wb(1'b0, STATUS_ADDR, 32'h0); chk(rd[ST_ERR], 1'b1, "error not latched");
      wb(1'b1, CTRL_ADDR, 32'h01);
      idle(10);
      chk(run_mode_o, 1'b0, "run accepted with latched error");
      wb(1'b1, CTRL_ADDR, 32'h04);
      clr_pc();
      pulse_host(1'b0, 1'b1);
      wait_run();
      chk({pc[0], pc[1], pc[2], pc[3]}, exp_pulses(RST_NONE), "plain start initialised");
      chk(first_restart_o, 1'b0, "main process not first");
      run_passes(60);
      wb(1'b1, CTRL_ADDR, 32'h40);
      pulse_host(1'b1, 1'b0);
      idle(12);
      chk(out_locked_o, 1'b1, "outputs not locked on halt");
      chk(out_units_o, 16'h0, "outputs not reset on halt");
      wb(1'b1, CTRL_ADDR, 32'h20);
      wb(1'b1, CTRL_ADDR, 32'h21);
      wait_run();
      chk(out_locked_o, 1'b1, "lock option ignored");
      run_passes(40);
      chk(out_units_o, 16'h0, "locked outputs written");
      wb(1'b1, CTRL_ADDR, 32'h80);
      idle(4);
      chk({run_mode_o, prog_run_o, out_locked_o}, 3'b100, "online load state");
      wb(1'b1, CTRL_ADDR, 32'h90);
      clr_pc();
      wb(1'b1, CTRL_ADDR, 32'h10);
      wait_run();
      chk({pc[0], pc[1], pc[2], pc[3]}, exp_pulses(RST_COLD), "no restart after load");
      // failed peripheral check must leave the block stopped
      periph_ok_i <= 1'b0;
      pulse_host(1'b1, 1'b0);
      idle(12);
      wb(1'b1, CTRL_ADDR, 32'h01);
      idle(12);
      chk(run_mode_o, 1'b0, "run entered with bad peripherals");
      print_verdict();
   end
endmodule : mode_seq_bench
